// [src/lvd_pkg.sv]
// package: shared constants and carrier types for the low-voltage detector control
// assumes: an 8-bit cpu register interface with byte and single-bit writes
package lvd_pkg;
  // control register bit positions
  localparam int CTL_FLAG_BIT = 0;
  localparam int CTL_MODE_BIT = 1;
  localparam int CTL_REF_BIT = 4;
  localparam int CTL_CMP_BIT = 7;
  // threshold field
  localparam int LEVEL_W = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h0;
  localparam logic [7:0] LEVEL_USED_MASK = 8'h07;
  // reset-cause bit position
  localparam int CAUSE_DETECTOR_BIT = 0;
  // settling times, software-timed; exported as cycle counts for reference
  localparam int CLK_HZ = 10_000_000;
  localparam int REF_SETTLE_US = 2000;
  localparam int CMP_SETTLE_US = 200;
  localparam int REF_SETTLE_CYC = (REF_SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int CMP_SETTLE_CYC = (CMP_SETTLE_US * (CLK_HZ / 1_000_000));

  // cpu write port towards the block
  typedef struct packed {
    logic ctl_byte_we;
    logic ctl_bit_we;
    logic [2:0] ctl_bit_sel;
    logic ctl_bit_val;
    logic level_we;
    logic [7:0] wdata;
  } cpu_wr_t;

  // visible state towards the cpu
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] level;
  } cpu_rd_t;
endpackage

// [src/lvd_sync.sv]
// three-stage synchroniser with agreement on stages two and three
// assumes: input is asynchronous to clk
`timescale 1ns/10ps
module lvd_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // data
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage <= {3{RESET_VAL}};
    end else begin
      stage <= {stage[1:0], async_in};
    end
  end

  // stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_out <= RESET_VAL;
    end else if (stage[1] == stage[2]) begin
      sync_out <= stage[2];
    end
  end
endmodule // lvd_sync

// [src/lvd_ctrl.sv]
// control logic of the supply low-voltage detector
// assumes: comparator output is async; cpu writes arrive as one-cycle strobes on clk;
// detector_reset_req is fed back by chip reset logic as detector_reset_active
`timescale 1ns/10ps

module lvd_ctrl #(
  parameter bit POC_BUILT = 1'b0
) (
  // clock and reset (external reset only)
  input wire logic clk,
  input wire logic nrst,
  // chip reset status: any reset other than external or own, and own reset
  input wire logic other_reset_active,
  input wire logic detector_reset_active,
  // cpu access
  input wire lvd_pkg::cpu_wr_t cpu_wr,
  output lvd_pkg::cpu_rd_t cpu_rd,
  // interrupt flag and mask access
  input wire logic irq_flag_clear,
  input wire logic irq_mask_we,
  input wire logic irq_mask_val,
  output logic detector_irq_request_flag,
  output logic detector_irq_mask,
  output logic low_supply_irq,
  // reset cause
  input wire logic cause_clear,
  output logic detector_reset_cause_bit,
  // analogue side
  input wire logic comparator_low,
  output logic reference_run,
  output logic comparator_run,
  output logic [lvd_pkg::LEVEL_W-1:0] threshold_select_field,
  output logic detector_reset_req
);
  initial begin
    if (lvd_pkg::LEVEL_W != 3) $error("threshold field must be three bits");
  end

  logic reference_enable;
  logic comparator_enable;
  logic reset_mode_select;
  logic low_supply_flag;
  logic low_sync;
  logic prev_irq_level;

  lvd_sync #(.RESET_VAL(1'b0)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(comparator_low),
    .sync_out(low_sync)
  );

  // bit writes and byte writes decoded once
  function automatic logic bit_hit(input lvd_pkg::cpu_wr_t w, input int pos);
    return w.ctl_bit_we && (w.ctl_bit_sel == 3'(pos));
  endfunction

  wire wr_ref = bit_hit(cpu_wr, lvd_pkg::CTL_REF_BIT);
  wire wr_cmp = bit_hit(cpu_wr, lvd_pkg::CTL_CMP_BIT);
  wire wr_mode = bit_hit(cpu_wr, lvd_pkg::CTL_MODE_BIT);
  wire byte_wr = cpu_wr.ctl_byte_we;

  wire next_ref = byte_wr ? cpu_wr.wdata[lvd_pkg::CTL_REF_BIT] :
                  wr_ref ? cpu_wr.ctl_bit_val : reference_enable;
  wire next_cmp = byte_wr ? cpu_wr.wdata[lvd_pkg::CTL_CMP_BIT] :
                  wr_cmp ? cpu_wr.ctl_bit_val : comparator_enable;
  wire next_mode = byte_wr ? cpu_wr.wdata[lvd_pkg::CTL_MODE_BIT] :
                   wr_mode ? cpu_wr.ctl_bit_val : reset_mode_select;

  // flag reads zero while the comparator is off; it can set during settling
  wire next_flag = comparator_enable && low_sync;
  // only a low supply in reset mode resets; mode select alone does not
  wire next_rst_req = comparator_enable && reset_mode_select && low_sync;
  wire irq_level = comparator_enable && !reset_mode_select && low_supply_flag;
  wire irq_edge = irq_level && !prev_irq_level;

  // own reset holds enables; other resets clear them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reference_enable <= 1'b0;
      comparator_enable <= 1'b0;
      reset_mode_select <= 1'b0;
    end else if (detector_reset_active) begin
      reference_enable <= reference_enable;
      comparator_enable <= comparator_enable;
      reset_mode_select <= reset_mode_select;
    end else if (other_reset_active) begin
      reference_enable <= 1'b0;
      comparator_enable <= 1'b0;
      reset_mode_select <= 1'b0;
    end else begin
      reference_enable <= next_ref;
      comparator_enable <= next_cmp;
      reset_mode_select <= next_mode;
    end
  end

  // level register: only the low three bits are stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      threshold_select_field <= lvd_pkg::LEVEL_RESET;
    end else if (cpu_wr.level_we) begin
      threshold_select_field <= cpu_wr.wdata[lvd_pkg::LEVEL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_supply_flag <= 1'b0;
      detector_reset_req <= 1'b0;
      prev_irq_level <= 1'b0;
      low_supply_irq <= 1'b0;
    end else begin
      low_supply_flag <= next_flag;
      detector_reset_req <= next_rst_req;
      prev_irq_level <= irq_level;
      low_supply_irq <= irq_level;
    end
  end

  // request flag: hardware set wins over software clear; mask does not gate the set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      detector_irq_request_flag <= 1'b0;
    end else if (irq_edge) begin
      detector_irq_request_flag <= 1'b1;
    end else if (irq_flag_clear) begin
      detector_irq_request_flag <= 1'b0;
    end
  end

  // external reset masks the interrupt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      detector_irq_mask <= 1'b1;
    end else if (irq_mask_we) begin
      detector_irq_mask <= irq_mask_val;
    end
  end

  // cause bit: set by own reset request, set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      detector_reset_cause_bit <= 1'b0;
    end else if (next_rst_req) begin
      detector_reset_cause_bit <= 1'b1;
    end else if (cause_clear) begin
      detector_reset_cause_bit <= 1'b0;
    end
  end

  // reference forced on when power-on-clear is built in
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reference_run <= POC_BUILT;
      comparator_run <= 1'b0;
      cpu_rd <= '0;
    end else begin
      reference_run <= POC_BUILT || reference_enable;
      comparator_run <= comparator_enable;
      cpu_rd.ctl <= {comparator_enable, 2'b00, reference_enable, 2'b00,
                     reset_mode_select, low_supply_flag};
      cpu_rd.level <= {5'h00, threshold_select_field};
    end
  end
endmodule // lvd_ctrl

// [sim/reset_logic_model.sv]
// chip reset logic model: answers the detector reset request
// assumes: the request is a level registered on clk
`timescale 1ns/10ps
module reset_logic_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request and status
  input wire logic detector_reset_req,
  output logic detector_reset_active
);
  // reset release is registered, so status trails the request by one edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) detector_reset_active <= 1'h0;
    else detector_reset_active <= detector_reset_req;
  end
endmodule // reset_logic_model

// [sim/lvd_ctrl_asserts.sv]
// checker: port-level properties of the detector control
// assumes: bound into lvd_ctrl, POC_BUILT handed on
`timescale 1ns/10ps
module lvd_ctrl_asserts #(
  parameter bit POC_BUILT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // reset status and comparator
  input wire logic other_reset_active,
  input wire logic detector_reset_active,
  input wire logic comparator_low,
  // observed outputs
  input wire logic low_supply_irq,
  input wire logic detector_irq_request_flag,
  input wire logic detector_irq_mask,
  input wire logic detector_reset_cause_bit,
  input wire logic reference_run,
  input wire logic comparator_run,
  input wire logic detector_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_cause_set;
    ##[1:6] detector_reset_cause_bit;
  endsequence
  property p_mask; $rose(nrst) |-> detector_irq_mask; endproperty
  property p_irq_on; low_supply_irq |-> comparator_run && !detector_reset_req; endproperty
  property p_irq_flag; $rose(low_supply_irq) |-> detector_irq_request_flag; endproperty
  property p_req_on; detector_reset_req |-> comparator_run; endproperty
  property p_cause; $rose(detector_reset_req) |-> s_cause_set; endproperty
  property p_sync; $rose(detector_reset_req) |-> $past(comparator_low, 2); endproperty
  property p_keep; detector_reset_active && comparator_run |=> comparator_run; endproperty
  property p_other;
    // enables clear one edge after, the run outputs one edge later still
    other_reset_active |-> ##2 (!comparator_run && (reference_run == POC_BUILT));
  endproperty
  a_mask: assert property (p_mask) else $error("mask low after reset");
  a_irq_on: assert property (p_irq_on) else $error("irq while off or reset mode");
  a_irq_flag: assert property (p_irq_flag) else $error("request flag not set");
  a_req_on: assert property (p_req_on) else $error("reset request while off");
  a_cause: assert property (p_cause) else $error("cause bit not set");
  a_sync: assert property (p_sync) else $error("request before sync delay");
  a_keep: assert property (p_keep) else $error("own reset cleared enable");
  a_other: assert property (p_other) else $error("other reset kept enables");
endmodule // lvd_ctrl_asserts
bind lvd_ctrl lvd_ctrl_asserts #(.POC_BUILT(POC_BUILT)) chk (.clk, .nrst,
  .other_reset_active, .detector_reset_active, .comparator_low, .low_supply_irq,
  .detector_irq_request_flag, .detector_irq_mask, .detector_reset_cause_bit,
  .reference_run, .comparator_run, .detector_reset_req);

// [sim/test_low_voltage_detector_control.sv]
// testbench: reset mode and interrupt mode runs of the detector control
// assumes: chip reset logic model in place of the real reset block
`timescale 1ns/10ps
module test_low_voltage_detector_control;
  logic clk = 1'h0, nrst = 1'h0, other_reset_active = 1'h0, comparator_low = 1'h0;
  logic irq_flag_clear = 1'h0, irq_mask_we = 1'h0, irq_mask_val = 1'h0, cause_clear = 1'h0;
  lvd_pkg::cpu_wr_t cpu_wr = '0;
  lvd_pkg::cpu_rd_t cpu_rd;
  logic detector_reset_active, detector_irq_request_flag, detector_irq_mask;
  logic low_supply_irq, detector_reset_cause_bit, reference_run, comparator_run;
  logic detector_reset_req;
  logic [2:0] threshold_select_field;
  int n_mismatch = 0, n_compared = 0;
  always #50 clk = ~clk;
  lvd_ctrl DUT (.clk, .nrst, .other_reset_active, .detector_reset_active, .cpu_wr,
    .cpu_rd, .irq_flag_clear, .irq_mask_we, .irq_mask_val, .detector_irq_request_flag,
    .detector_irq_mask, .low_supply_irq, .cause_clear, .detector_reset_cause_bit,
    .comparator_low, .reference_run, .comparator_run, .threshold_select_field,
    .detector_reset_req);
  reset_logic_model partner (.clk, .nrst, .detector_reset_req, .detector_reset_active);
  function automatic logic [7:0] z(input logic x);
    return {7'h00, x};
  endfunction
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic b, t, l, input logic [2:0] s, input logic [7:0] d);
    cpu_wr = '{b, t, s, d[0], l, d};
    wt(1);
    cpu_wr = '0;
  endtask
  task results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results;
  end
  initial begin
    wt(2);
    nrst = 1'h1;
    chk("mask", 8'h01, z(detector_irq_mask));
    wr(1'h0, 1'h0, 1'h1, 3'h0, 8'h05);
    wr(1'h0, 1'h1, 1'h0, 3'h4, 8'h01);
    wr(1'h0, 1'h1, 1'h0, 3'h7, 8'h01);
    wr(1'h0, 1'h1, 1'h0, 3'h1, 8'h01);
    wt(8);
    chk("level", 8'h05, cpu_rd.level);
    chk("ctl", 8'h92, cpu_rd.ctl);
    chk("ref run", 8'h01, z(reference_run));
    chk("cmp run", 8'h01, z(comparator_run));
    chk("field", 8'h05, {5'h00, threshold_select_field});
    chk("rst", 8'h00, z(detector_reset_req));
    comparator_low = 1'h1;
    wt(8);
    chk("rst", 8'h01, z(detector_reset_req));
    chk("cause", 8'h01, z(detector_reset_cause_bit));
    chk("ctl", 8'h93, cpu_rd.ctl);
    comparator_low = 1'h0;
    wt(8);
    cause_clear = 1'h1;
    wr(1'h1, 1'h0, 1'h0, 3'h0, 8'h00);
    cause_clear = 1'h0;
    wt(2);
    chk("cause", 8'h00, z(detector_reset_cause_bit));
    chk("ctl", 8'h00, cpu_rd.ctl);
    $display("reset mode test done");
    irq_mask_we = 1'h1;
    irq_mask_val = 1'h1;
    wt(1);
    irq_mask_we = 1'h0;
    irq_mask_val = 1'h0;
    chk("mask", 8'h01, z(detector_irq_mask));
    wr(1'h0, 1'h1, 1'h0, 3'h4, 8'h01);
    wr(1'h0, 1'h1, 1'h0, 3'h7, 8'h01);
    comparator_low = 1'h1;
    wt(8);
    chk("irq", 8'h01, z(low_supply_irq));
    chk("req flag", 8'h01, z(detector_irq_request_flag));
    chk("rst", 8'h00, z(detector_reset_req));
    irq_flag_clear = 1'h1;
    irq_mask_we = 1'h1;
    wt(1);
    irq_flag_clear = 1'h0;
    irq_mask_we = 1'h0;
    wt(1);
    chk("req flag", 8'h00, z(detector_irq_request_flag));
    chk("mask", 8'h00, z(detector_irq_mask));
    comparator_low = 1'h0;
    wt(8);
    chk("irq", 8'h00, z(low_supply_irq));
    wr(1'h0, 1'h1, 1'h0, 3'h7, 8'h00);
    wr(1'h0, 1'h1, 1'h0, 3'h4, 8'h00);
    wt(2);
    chk("ctl", 8'h00, cpu_rd.ctl);
    chk("cmp run", 8'h00, z(comparator_run));
    wr(1'h0, 1'h1, 1'h0, 3'h4, 8'h01);
    wr(1'h0, 1'h1, 1'h0, 3'h7, 8'h01);
    wt(2);
    chk("ctl", 8'h90, cpu_rd.ctl);
    other_reset_active = 1'h1;
    wt(1);
    other_reset_active = 1'h0;
    wt(2);
    chk("ctl", 8'h00, cpu_rd.ctl);
    chk("cmp run", 8'h00, z(comparator_run));
    $display("interrupt mode test done");
    results;
  end
endmodule // test_low_voltage_detector_control
